/* File: hw/uep_consts.vh */
// Purpose: Shared constants for the erasable memory programmer
// Assumes: 25 MHz core clock, 40 ns period
// Notes:   Times are given in their own unit, counts derive from them
`ifndef UEP_CONSTS_VH
`define UEP_CONSTS_VH

// ****************************************
// Clock and timing
// ****************************************
`define UEP_CLK_KHZ          25000
`define UEP_FPW_US           1000
`define UEP_FPW_CYC          ((`UEP_FPW_US * `UEP_CLK_KHZ) / 1000)
`define UEP_CPW_US           50000
`define UEP_CPW_CYC          ((`UEP_CPW_US * `UEP_CLK_KHZ) / 1000)
`define UEP_SETUP_US         2
`define UEP_SETUP_CYC        ((`UEP_SETUP_US * `UEP_CLK_KHZ) / 1000)
`define UEP_OE_US            20
`define UEP_OE_CYC           ((`UEP_OE_US * `UEP_CLK_KHZ) / 1000)
`define UEP_SUPPLY_US        2
`define UEP_SUPPLY_CYC       ((`UEP_SUPPLY_US * `UEP_CLK_KHZ) / 1000)

// ****************************************
// Algorithm figures
// ****************************************
`define UEP_MAX_ROUNDS       15
`define UEP_OVER_FACTOR      4
`define UEP_ADDR_W           14
`define UEP_DATA_W           8

`endif

/* File: hw/uep_timer.v */
// Purpose: Loadable down counter that times strobes and setup gaps
// Assumes: Load and count on the same core clock
// Notes:   Done is high while the count rests at zero
`timescale 1ns/1ps
module uep_timer #(
    parameter W = 24
) (
    // Clock and reset
    input  wire         core_clk_in,
    input  wire         rst_b_in,
    // Control
    input  wire         load_in,
    input  wire [W-1:0] value_in,
    // Status
    output wire         done_out
);
    reg [W-1:0] count;   // Remaining cycles

    // ****************************************
    // Count down from the loaded value
    // ****************************************
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count <= {W{1'b0}};
        end else if (load_in) begin
            count <= value_in;
        end else if (count != {W{1'b0}}) begin
            count <= count - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done_out = (count == {W{1'b0}});
endmodule // uep_timer

/* File: hw/uep_prog.v */
// Purpose: Host controller that reads and programs an erasable memory
// Assumes: Memory pins driven directly; supplies switched by enables
// Notes:   Fast and conventional write algorithms, plus plain reads
// Function
// - Raise supplies with first write address, before its data
// - Verify each 1 ms pulse by reading
// - Repeat pulses until match or fifteen
// - Count pulses applied per location
// - Overprogram pulse lasts four times count
// - Overprogram pulse 3.8 to 63 ms
// - Initial fast pulse 0.95 to 1.05 ms
// - Step address up to last location
// - Drive all eight data bits in parallel
// - Conventional: one pulse, 45 to 55 ms
`timescale 1ns/1ps
`include "uep_consts.vh"
module uep_prog #(
    parameter AW     = `UEP_ADDR_W,
    parameter DW     = `UEP_DATA_W,
    parameter TW     = 24,
    parameter FPW    = `UEP_FPW_CYC,
    parameter CPW    = `UEP_CPW_CYC
) (
    // Clock and reset
    input  wire          core_clk_in,
    input  wire          rst_b_in,
    // User command side
    input  wire          start_in,
    input  wire [1:0]    op_in,
    input  wire [AW-1:0] first_addr_in,
    input  wire [AW-1:0] last_addr_in,
    output reg           data_req_out,
    output reg  [AW-1:0] data_req_addr_out,
    input  wire [DW-1:0] wr_data_in,
    output reg  [DW-1:0] rd_data_out,
    output reg           rd_valid_out,
    output reg           busy_out,
    output reg           done_out,
    output reg           fail_out,
    // Memory pins
    output reg  [AW-1:0] word_address_out,
    output reg           chip_sel_n_out,
    output reg           out_gate_n_out,
    output reg           program_strobe_n_out,
    output reg           prog_supply_en_out,
    output reg           core_6v_en_out,
    output reg  [DW-1:0] data_lines_out,
    output reg           data_lines_oe_out,
    input  wire [DW-1:0] data_lines_in
);
    // Operation codes
    localparam OP_READ  = 2'h0;
    localparam OP_FAST  = 2'h1;
    localparam OP_CONV  = 2'h2;
    // States
    localparam S_IDLE   = 4'h0;
    localparam S_PWR    = 4'h1;
    localparam S_ADDR   = 4'h2;
    localparam S_PULSE  = 4'h3;
    localparam S_VOE    = 4'h4;
    localparam S_VCMP   = 4'h5;
    localparam S_OVER   = 4'h6;
    localparam S_NEXT   = 4'h7;
    localparam S_RDOE   = 4'h8;
    localparam S_RDCAP  = 4'h9;
    localparam S_PWROFF = 4'ha;
    localparam S_DREQ   = 4'hb;
    reg  [3:0]    state;       // Sequencer state
    reg  [1:0]    op;          // Latched operation
    reg  [AW-1:0] last_addr;   // Final location
    reg  [DW-1:0] wdata;       // Word being written
    reg  [4:0]    pulses;      // Pulses applied here
    reg           tload;       // Timer load strobe
    reg  [TW-1:0] tval;        // Timer load value
    wire          tdone;       // Timer idle
    reg  [DW-1:0] din_s1, din_s2, din_s3;  // Three-stage sampling of data pins
    // Cycles of an overprogram pulse for a given pulse count, full width
    function [31:0] over_cycles;
        input [4:0] n;
        over_cycles = FPW * `UEP_OVER_FACTOR * n;
    endfunction
    // Timer load for a wait; a strobe loses one edge to the load and one to done
    function [TW-1:0] tload_val;
        input [31:0] v;
        input        strobe;
        tload_val = v[TW-1:0] - {{(TW-2){1'b0}}, strobe, 1'b0};
    endfunction

    uep_timer #(.W(TW)) u_timer (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .load_in     (tload),
        .value_in    (tval),
        .done_out    (tdone)
    );
    // ****************************************
    // Data pin sampling
    // ****************************************
    // Read data is stable well before sampled; stages 2 and 3 must agree
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            din_s1 <= {DW{1'b0}};
            din_s2 <= {DW{1'b0}};
            din_s3 <= {DW{1'b0}};
        end else begin
            din_s1 <= data_lines_in;
            din_s2 <= din_s1;
            din_s3 <= din_s2;
        end
    end
    // ****************************************
    // Sequencer
    // ****************************************
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state                <= S_IDLE;
            op                   <= OP_READ;
            last_addr            <= {AW{1'b0}};
            wdata                <= {DW{1'b0}};
            pulses               <= 5'h00;
            tload                <= 1'b0;
            tval                 <= {TW{1'b0}};
            data_req_out         <= 1'b0;
            data_req_addr_out    <= {AW{1'b0}};
            rd_data_out          <= {DW{1'b0}};
            rd_valid_out         <= 1'b0;
            busy_out             <= 1'b0;
            done_out             <= 1'b0;
            fail_out             <= 1'b0;
            word_address_out     <= {AW{1'b0}};
            chip_sel_n_out       <= 1'b1;
            out_gate_n_out       <= 1'b1;
            program_strobe_n_out <= 1'b1;
            prog_supply_en_out   <= 1'b0;
            core_6v_en_out       <= 1'b0;
            data_lines_out       <= {DW{1'b0}};
            data_lines_oe_out    <= 1'b0;
        end else begin
            // Pulses default low
            tload        <= 1'b0;
            data_req_out <= 1'b0;
            rd_valid_out <= 1'b0;
            done_out     <= 1'b0;
            case (state)
                S_IDLE: begin
                    // Standby: chip-select high floats the memory
                    chip_sel_n_out <= 1'b1;
                    out_gate_n_out <= 1'b1;
                    if (start_in) begin
                        op               <= op_in;
                        last_addr        <= last_addr_in;
                        word_address_out <= first_addr_in;
                        busy_out         <= 1'b1;
                        fail_out         <= 1'b0;
                        if (op_in == OP_READ) begin
                            chip_sel_n_out <= 1'b0;
                            out_gate_n_out <= 1'b0;  // Read mode
                            tload          <= 1'b1;
                            tval           <= tload_val(`UEP_SETUP_CYC, 1'b0);
                            state          <= S_RDOE;
                        end else begin
                            // Supplies and address together, data afterwards
                            prog_supply_en_out <= 1'b1;
                            core_6v_en_out     <= (op_in == OP_FAST);
                            tload              <= 1'b1;
                            tval               <= tload_val(`UEP_SUPPLY_CYC, 1'b0);
                            state              <= S_PWR;
                        end
                    end
                end
                S_RDOE: begin
                    if (tdone && !tload) begin
                        state <= S_RDCAP;
                    end
                end
                S_RDCAP: begin
                    // Settled word taken once the sampled stages agree
                    if (din_s2 == din_s3) begin
                        rd_data_out  <= din_s3;
                        rd_valid_out <= 1'b1;
                        state        <= S_NEXT;
                    end
                end
                S_PWR: begin
                    if (tdone && !tload) begin
                        state <= S_DREQ;
                    end
                end
                S_DREQ: begin
                    // Ask for this location's word; user answers next cycle
                    data_req_out      <= 1'b1;
                    data_req_addr_out <= word_address_out;
                    state             <= S_ADDR;
                    pulses            <= 5'h00;
                end
                S_ADDR: begin
                    if (!data_req_out) begin
                        // Present address and all data bits
                        wdata             <= wr_data_in;
                        data_lines_out    <= wr_data_in;
                        data_lines_oe_out <= 1'b1;
                        chip_sel_n_out    <= 1'b0;
                        tload             <= 1'b1;
                        tval              <= tload_val((op == OP_FAST) ? FPW : CPW, 1'b1);
                        program_strobe_n_out <= 1'b0;
                        pulses            <= pulses + 5'h01;
                        state             <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    if (tdone && !tload) begin
                        program_strobe_n_out <= 1'b1;
                        data_lines_oe_out    <= 1'b0;
                        if (op == OP_CONV) begin
                            state <= S_NEXT;  // Single pulse per location
                        end else begin
                            tload <= 1'b1;
                            tval  <= tload_val(`UEP_OE_CYC, 1'b0);
                            state <= S_VOE;
                        end
                    end
                end
                S_VOE: begin
                    // Verify read after each 1 ms fast pulse
                    out_gate_n_out <= 1'b0;
                    if (tdone && !tload && (din_s2 == din_s3)) begin
                        state <= S_VCMP;
                    end
                end
                S_VCMP: begin
                    // Either way a strobe starts with the word driven again
                    out_gate_n_out       <= 1'b1;
                    data_lines_oe_out    <= 1'b1;
                    program_strobe_n_out <= 1'b0;
                    tload                <= 1'b1;
                    if (din_s3 == wdata || pulses == `UEP_MAX_ROUNDS) begin
                        // Loop over: overprogram 4 x count ms
                        fail_out <= (din_s3 != wdata);
                        tval     <= tload_val(over_cycles(pulses), 1'b1);
                        state    <= S_OVER;
                    end else begin
                        // Another 1 ms round
                        tval   <= tload_val(FPW, 1'b1);
                        pulses <= pulses + 5'h01;
                        state  <= S_PULSE;
                    end
                end
                S_OVER: begin
                    if (tdone && !tload) begin
                        program_strobe_n_out <= 1'b1;
                        data_lines_oe_out    <= 1'b0;
                        state                <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    // Step through to the last address
                    out_gate_n_out <= 1'b1;
                    if (word_address_out == last_addr || fail_out) begin
                        chip_sel_n_out     <= 1'b1;
                        prog_supply_en_out <= 1'b0;
                        tload              <= 1'b1;
                        tval               <= tload_val(`UEP_SUPPLY_CYC, 1'b0);
                        state              <= S_PWROFF;
                    end else begin
                        word_address_out <= word_address_out + {{(AW-1){1'b0}}, 1'b1};
                        if (op == OP_READ) begin
                            out_gate_n_out <= 1'b0;
                            tload          <= 1'b1;
                            tval           <= tload_val(`UEP_SETUP_CYC, 1'b0);
                            state          <= S_RDOE;
                        end else begin
                            state <= S_DREQ;
                        end
                    end
                end
                S_PWROFF: begin
                    // Core supply removed after the program supply
                    if (tdone && !tload) begin
                        core_6v_en_out <= 1'b0;
                        busy_out       <= 1'b0;
                        done_out       <= 1'b1;
                        state          <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // uep_prog

/* File: tb/uep_prog_monitor.sv */
// Purpose: Assertions on the memory pins of the programmer
// Assumes: One core clock, reset asynchronous and active low
// Notes:   Strobe widths are judged in core cycles from FPW and CPW
`timescale 1ns/1ps
module uep_prog_monitor #(
    parameter AW  = 14,
    parameter DW  = 8,
    parameter FPW = 10,
    parameter CPW = 40
) (
    // Clock and reset
    input wire          core_clk_in,
    input wire          rst_b_in,
    // Memory pins
    input wire [AW-1:0] word_address_out,
    input wire          chip_sel_n_out,
    input wire          out_gate_n_out,
    input wire          program_strobe_n_out,
    input wire          prog_supply_en_out,
    input wire          core_6v_en_out,
    input wire [DW-1:0] data_lines_out,
    input wire          data_lines_oe_out,
    input wire          data_req_out
);
    // ****************************************
    // Helper counters
    // ****************************************
    reg [31:0]   low_cnt;   // Cycles the strobe has been low so far
    reg [4:0]    rounds;    // Nominal pulses at the present address
    reg [AW-1:0] last_addr; // Address at the previous edge
    // A non-zero count with the strobe high marks the edge just after a pulse
    wire strobe_rise = program_strobe_n_out && (low_cnt != 32'h0);

    // Count strobe width, and nominal pulses until the address moves on
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            low_cnt   <= 32'h0;
            rounds    <= 5'h0;
            last_addr <= {AW{1'b0}};
        end else begin
            last_addr <= word_address_out;
            low_cnt   <= program_strobe_n_out ? 32'h0 : low_cnt + 32'h1;
            if (word_address_out != last_addr)
                rounds <= 5'h0;
            else if (strobe_rise && core_6v_en_out && low_cnt == FPW)
                rounds <= rounds + 5'h1;
        end
    end

    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_nominal_end;
        strobe_rise && core_6v_en_out && low_cnt == FPW;
    endsequence
    sequence s_verify_read;
        ##[1:100] (!out_gate_n_out && !chip_sel_n_out);
    endsequence

    a_strobe_has_supply: assert property (
        !program_strobe_n_out |-> prog_supply_en_out && !chip_sel_n_out)
        else $error("strobe low without supply or select");
    a_write_data_driven: assert property (
        !program_strobe_n_out |-> data_lines_oe_out && out_gate_n_out)
        else $error("strobe low without host data");
    a_strobe_data_steady: assert property (
        !program_strobe_n_out && !$past(program_strobe_n_out)
        |-> $stable(data_lines_out) && $stable(word_address_out))
        else $error("data or address moved under the strobe");
    a_no_bus_fight: assert property (
        !out_gate_n_out && !chip_sel_n_out |-> !data_lines_oe_out)
        else $error("host drives while memory outputs");
    a_verify_after_pulse: assert property (s_nominal_end |-> s_verify_read)
        else $error("no read back after a nominal pulse");
    a_fast_pulse_width: assert property (
        strobe_rise && core_6v_en_out |-> low_cnt == FPW
        || (low_cnt * 100 >= 380 * FPW && low_cnt <= 63 * FPW))
        else $error("fast strobe width out of range");
    a_conv_pulse_width: assert property (
        strobe_rise && !core_6v_en_out |-> low_cnt * 10 >= 9 * CPW && low_cnt * 10 <= 11 * CPW)
        else $error("conventional strobe width out of range");
    a_overprogram_len: assert property (
        strobe_rise && core_6v_en_out && low_cnt != FPW |-> low_cnt == 4 * rounds * FPW)
        else $error("overprogram width not four times count");
    a_round_limit: assert property (rounds <= 5'd15)
        else $error("more than fifteen nominal pulses");
    a_supply_first: assert property (data_req_out |-> prog_supply_en_out)
        else $error("write word asked before supply is up");
endmodule // uep_prog_monitor

bind uep_prog uep_prog_monitor #(.AW(AW), .DW(DW), .FPW(FPW), .CPW(CPW)) u_mon (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .word_address_out(word_address_out),
    .chip_sel_n_out(chip_sel_n_out), .out_gate_n_out(out_gate_n_out),
    .program_strobe_n_out(program_strobe_n_out), .prog_supply_en_out(prog_supply_en_out),
    .core_6v_en_out(core_6v_en_out), .data_lines_out(data_lines_out),
    .data_lines_oe_out(data_lines_oe_out), .data_req_out(data_req_out));

/* File: tb/uep_mem_model.sv */
// Purpose: Behavioural erasable memory on the far side of the programmer
// Assumes: Cells only clear bits; erased words read all ones
// Notes:   need_pulses_in sets how many strobes a word takes to stick
`timescale 1ns/1ps
module uep_mem_model (
    // Clock, samples the strobe pins and remembers the last bus value
    input  wire        core_clk_in,
    // Memory pins
    input  wire [13:0] word_address_in,
    input  wire        chip_sel_n_in,
    input  wire        out_gate_n_in,
    input  wire        program_strobe_n_in,
    input  wire        prog_supply_en_in,
    input  wire [7:0]  host_data_in,
    input  wire        host_oe_in,
    output wire [7:0]  data_lines_out,
    // Scenario control
    input  wire [4:0]  need_pulses_in
);
    reg [7:0]  mem [0:16383]; // 16384 words of 8 bits
    reg [7:0]  last;          // Last driven value, floating shows its inverse
    reg [4:0]  pulses;        // Strobes seen at pulse_addr
    reg [13:0] pulse_addr;    // Word that the strobes went to
    reg        in_pulse;      // A strobe is under way
    reg [7:0]  pdata;         // Word driven by the host during the strobe
    integer    i;
    // Output only with both selects low and no strobe
    wire mem_drive = !chip_sel_n_in && !out_gate_n_in && program_strobe_n_in;
    // Programming needs raised supply and select
    wire prog_ok   = prog_supply_en_in && !chip_sel_n_in;
    // No pull on the lines, so a released bus never repeats its last value
    assign data_lines_out = host_oe_in ? host_data_in : mem_drive ? mem[word_address_in] : ~last;

    initial begin
        for (i = 0; i < 16384; i = i + 1)
            mem[i] = 8'hff;
        last       = 8'h00;
        pulses     = 5'h0;
        pulse_addr = 14'h0;
        in_pulse   = 1'b0;
        pdata      = 8'hff;
    end

    // Remember what was last driven
    always @(posedge core_clk_in) begin
        if (host_oe_in || mem_drive)
            last <= data_lines_out;
    end

    // Count strobes at a word, clear bits when a strobe ends with the count at need_pulses_in or more
    // Sampled on the clock so pins that move on one edge never race each other
    always @(posedge core_clk_in) begin
        if (!program_strobe_n_in && prog_ok) begin
            if (!in_pulse) begin
                pulses     <= (word_address_in == pulse_addr) ? pulses + 5'h1 : 5'h1;
                pulse_addr <= word_address_in;
            end
            in_pulse <= 1'b1;
            pdata    <= host_oe_in ? host_data_in : 8'hff;
        end else if (program_strobe_n_in && in_pulse) begin
            in_pulse <= 1'b0;
            if (pulses >= need_pulses_in)
                mem[pulse_addr] <= mem[pulse_addr] & pdata;
        end
    end
endmodule // uep_mem_model

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the memory programmer
// Assumes: Memory model on the pins, pulse units shortened to 10 and 40
// Notes:   Each scenario runs operations and checks what comes back
`timescale 1ns/1ps
module tb_top;
    // ****************************************
    // Signals
    // ****************************************
    reg         core_clk_in   = 1'b0;  // 25 MHz core clock
    reg         rst_b_in      = 1'b0;  // Reset held low at start
    reg         start_in      = 1'b0;
    reg  [1:0]  op_in         = 2'h0;
    reg  [13:0] first_addr_in = 14'h0;
    reg  [13:0] last_addr_in  = 14'h0;
    reg  [7:0]  wr_data_in    = 8'h00;
    reg  [4:0]  need          = 5'h01; // Strobes a word takes in the model
    wire [13:0] req_addr, addr;
    wire [7:0]  rd_data, lines_out, lines_in;
    wire        data_req, rd_valid, busy, done, fail, cs_n, oe_n, pgm_n, vpp, vcc6, lines_oe;
    integer     err_count = 0, total_checks = 0, pulses = 0, i;
    reg  [7:0]  shadow [0:16383];      // Expected memory contents

    always #20 core_clk_in = ~core_clk_in;
    always @(negedge pgm_n) pulses = pulses + 1;

    uep_prog #(.FPW(10), .CPW(40)) dut (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .start_in(start_in), .op_in(op_in),
        .first_addr_in(first_addr_in), .last_addr_in(last_addr_in), .data_req_out(data_req),
        .data_req_addr_out(req_addr), .wr_data_in(wr_data_in), .rd_data_out(rd_data),
        .rd_valid_out(rd_valid), .busy_out(busy), .done_out(done), .fail_out(fail),
        .word_address_out(addr), .chip_sel_n_out(cs_n), .out_gate_n_out(oe_n),
        .program_strobe_n_out(pgm_n), .prog_supply_en_out(vpp), .core_6v_en_out(vcc6),
        .data_lines_out(lines_out), .data_lines_oe_out(lines_oe), .data_lines_in(lines_in));
    uep_mem_model u_mem (
        .core_clk_in(core_clk_in), .word_address_in(addr), .chip_sel_n_in(cs_n),
        .out_gate_n_in(oe_n), .program_strobe_n_in(pgm_n), .prog_supply_en_in(vpp),
        .host_data_in(lines_out), .host_oe_in(lines_oe), .data_lines_out(lines_in),
        .need_pulses_in(need));

    // ****************************************
    // Shared tasks
    // ****************************************
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // One operation; serves write words, checks read words; poke retries start while busy
    task run(input [1:0] op, input [13:0] fa, input [13:0] la, input [4:0] nd, input poke);
        integer     n;
        reg  [13:0] ra;
        begin
            @(negedge core_clk_in);
            op_in = op;
            first_addr_in = fa;
            last_addr_in = la;
            need = nd;
            pulses = 0;
            ra = fa;
            start_in = 1'b1;
            n = 0;
            @(negedge core_clk_in);
            while (done !== 1'b1 && n < 40000) begin
                start_in = poke && (n == 10);
                if (data_req === 1'b1) begin
                    wr_data_in = req_addr[7:0] ^ 8'h5a;
                    chk(vpp, 1'b1);
                    chk(req_addr, ra);
                    ra = ra + 14'h1;
                end
                if (rd_valid === 1'b1) begin
                    chk(rd_data, shadow[ra]);
                    ra = ra + 14'h1;
                end
                @(negedge core_clk_in);
                n = n + 1;
            end
            if (n >= 40000) begin
                err_count = err_count + 1;
                print_verdict;
            end
            chk(ra, {la + 14'h1});
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task sc_read_top; // Erased top words, with a start poked in while busy
        begin
            run(2'h0, 14'h3ffe, 14'h3fff, 5'h1, 1'b1);
            chk(pulses, 0);
            repeat (3) @(negedge core_clk_in);
            chk(busy, 1'b0);
            chk(cs_n, 1'b1);
        end
    endtask

    task sc_fast_quick; // Words that verify after one strobe, then read back
        begin
            for (i = 5; i < 8; i = i + 1)
                shadow[i] = i[7:0] ^ 8'h5a;
            run(2'h1, 14'h5, 14'h7, 5'h1, 1'b0);
            chk(pulses, 6);
            chk(fail, 1'b0);
            run(2'h0, 14'h5, 14'h7, 5'h1, 1'b0);
        end
    endtask

    task sc_fast_slow; // Word that sticks on the fifteenth strobe
        begin
            shadow[20] = 8'h14 ^ 8'h5a;
            run(2'h1, 14'd20, 14'd20, 5'd15, 1'b0);
            chk(pulses, 16);
            chk(fail, 1'b0);
            run(2'h0, 14'd20, 14'd20, 5'h1, 1'b0);
        end
    endtask

    task sc_fast_fail; // Word that never sticks: fifteen rounds then failure
        begin
            run(2'h1, 14'd30, 14'd30, 5'd31, 1'b0);
            chk(pulses, 16);
            chk(fail, 1'b1);
            run(2'h0, 14'd30, 14'd30, 5'h1, 1'b0);
            chk(fail, 1'b0);
        end
    endtask

    task sc_conv; // One long strobe per word, then read back
        begin
            shadow[40] = 8'h28 ^ 8'h5a;
            shadow[41] = 8'h29 ^ 8'h5a;
            run(2'h2, 14'd40, 14'd41, 5'h1, 1'b0);
            chk(pulses, 2);
            run(2'h0, 14'd40, 14'd41, 5'h1, 1'b0);
        end
    endtask

    // Main sequence
    initial begin
        for (i = 0; i < 16384; i = i + 1)
            shadow[i] = 8'hff;
        repeat (2) @(negedge core_clk_in);
        rst_b_in = 1'b1;
        sc_read_top;
        sc_fast_quick;
        sc_fast_slow;
        sc_fast_fail;
        sc_conv;
        print_verdict;
    end
endmodule // tb_top
